// ### adcs_top.sv
// digital control and serial port of a charge-integrating converter
// assumes mclk is the system clock; pins are asynchronous to it
// Notes on behaviour
// R1: host transmits only after data valid
// R2: host holds transmit until chain emptied
// R3: readback high selects result onto output
// R4: readback low loads setup copy on rise
// R5: setup copy sits between chain in, out
// R6: readback leaves result and conversion untouched
// R7: setup word is twelve bits
// R8: twelve rising data clocks capture setup bits
// R9: setup reset clears setup register only
// R10: test input connects test current source
// R11: async trigger held at least M clocks
// R12: continuous trigger shorter than M-1 clocks
// R13: async: integration restarts on trigger release
// R14: data valid falls with system clock
// R15: transmit low raises valid, drives data
// R16: transmit high floats serial output
// R17: host lowers data clock before transmit
// R18: host releases setup reset before capture
// R19: overflow flags clear on system clock
// R20: single part transmits within LxN-21 clocks
// R21: output advances after falling data clock
// R22: continuous: restart exactly M clocks after
// R23: result 21-bit twos or 20-bit straight, msb first
// R24: chain bits follow own result bits
// R25: data valid held until transmit
`timescale 1ns/1ps
`include "adcs_defines.svh"
module adcs_top
  import adcs_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            awaddr,
  input  wire logic                   wvalid,
  output logic                        wready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  output logic                        bvalid,
  input  wire logic                   bready,
  output logic [1:0]                  bresp,
  input  wire logic                   arvalid,
  output logic                        arready,
  input  wire logic [31:0]            araddr,
  output logic                        rvalid,
  input  wire logic                   rready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  input  wire logic                   dclk,
  input  wire logic                   din,
  input  wire logic                   xmit_n,
  input  wire logic                   rdsel,
  input  wire logic                   setup_din,
  input  wire logic                   setup_rst_n,
  input  wire logic                   final_point_trigger_n,
  input  wire logic                   test_in,
  input  wire logic [`ADCS_RES_W-1:0] conv_result,
  input  wire logic                   ovf_pos_in,
  input  wire logic                   ovf_neg_in,
  output logic                        dout,
  output logic                        dout_oe,
  output logic                        data_valid_n,
  output logic                        ovf_pos_pull,
  output logic                        ovf_neg_pull,
  output logic                        test_src_en,
  output logic                        integ_start
);
  // ----------------------------------------
  // pin synchronisers and edge finding
  // ----------------------------------------
  adcs_pins_t pins_raw;
  adcs_pins_t pins_s;
  logic       dclk_d_r;
  logic       xmit_d_r;
  logic       trig_d_r;
  logic       dclk_rise;
  logic       dclk_fall;
  logic       tx_on;
  logic       tx_start;
  logic       trig_rise;

  assign pins_raw = '{dclk: dclk, din: din, xmit_n: xmit_n, rdsel: rdsel,
                      setup_din: setup_din, setup_rst_n: setup_rst_n,
                      trig_n: final_point_trigger_n, test: test_in};

  // reset to the idle level of every pin, so no false edge follows reset
  adcs_sync #(.W($bits(adcs_pins_t)), .INI(8'h76)) u_sync (
    .clk   (mclk),
    .rst_n (resetn),
    .d     (pins_raw),
    .q     (pins_s)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dclk_d_r <= 1'b0;
      xmit_d_r <= 1'b1;
      trig_d_r <= 1'b1;
    end else begin
      dclk_d_r <= pins_s.dclk;
      xmit_d_r <= pins_s.xmit_n;
      trig_d_r <= pins_s.trig_n;
    end
  end

  assign dclk_rise = pins_s.dclk & ~dclk_d_r;
  assign dclk_fall = ~pins_s.dclk & dclk_d_r;
  assign tx_on     = ~pins_s.xmit_n;
  assign tx_start  = tx_on & xmit_d_r;
  assign trig_rise = pins_s.trig_n & ~trig_d_r;

  // ----------------------------------------
  // setup word capture
  // ----------------------------------------
  adcs_cfg_t        cfg_r;
  adcs_cfg_t        cfg_nxt;
  logic [3:0]       cap_cnt_r;
  logic [3:0]       cap_cnt_nxt;

  always_comb begin
    cfg_nxt     = cfg_r;
    cap_cnt_nxt = cap_cnt_r;
    if (!pins_s.setup_rst_n) begin
      cfg_nxt     = '0;                                          // R9
      cap_cnt_nxt = 4'(`ADCS_CFG_W);
    end else if (dclk_rise && cap_cnt_r != 4'h0) begin
      cfg_nxt     = adcs_cfg_t'({cfg_r[`ADCS_CFG_W-2:0], pins_s.setup_din}); // R8 R7
      cap_cnt_nxt = cap_cnt_r - 4'h1;
    end
  end

  // setup reset acts only here, through its synchronised level
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfg_r     <= '0;
      cap_cnt_r <= 4'h0;
    end else begin
      cfg_r     <= cfg_nxt;
      cap_cnt_r <= cap_cnt_nxt;
    end
  end

  // ----------------------------------------
  // conversion timing and handshake
  // ----------------------------------------
  adcs_state_t            st_r;
  adcs_state_t            st_nxt;
  logic [`ADCS_CNT_W-1:0] cnt_r;
  logic [`ADCS_CNT_W-1:0] cnt_nxt;
  logic [`ADCS_CNT_W-1:0] m_cnt;
  logic                   cont_r;
  logic                   cont_nxt;
  logic                   istart_r;
  logic                   istart_nxt;
  logic                   dv_n_r;
  logic                   dv_n_nxt;
  logic                   ovfp_r;
  logic                   ovfp_nxt;
  logic                   ovfn_r;
  logic                   ovfn_nxt;
  logic                   ovf_clr_r;
  logic                   ovf_clr_nxt;
  logic [`ADCS_RES_W-1:0] res_hold_r;
  logic [`ADCS_RES_W-1:0] res_hold_nxt;
  logic                   done;
  logic                   coll;
  logic [1:0]             ctrl_r;

  assign m_cnt = {1'b0, cfg_r.osr} + 7'h01;
  assign coll  = (st_r == ST_COLLECT);

  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    cont_nxt     = cont_r;
    istart_nxt   = 1'b0;
    done         = 1'b0;
    res_hold_nxt = res_hold_r;
    unique case (st_r)
      ST_IDLE: begin
        if (!pins_s.trig_n) begin
          st_nxt   = ST_COLLECT;
          cnt_nxt  = 7'h01;
          cont_nxt = ctrl_r[`ADCS_CTRL_CONT];
        end
      end
      ST_COLLECT: begin
        if (cnt_r >= m_cnt) begin
          done         = 1'b1;
          res_hold_nxt = conv_result;
          if (cont_r) begin
            istart_nxt = 1'b1;                                   // R22
            st_nxt     = ST_IDLE;
          end else begin
            st_nxt = ST_HOLD;
          end
        end else begin
          cnt_nxt = cnt_r + 7'h01;
        end
      end
      ST_HOLD: begin
        // async mode waits for the trigger to be released
        if (trig_rise || pins_s.trig_n) begin
          istart_nxt = 1'b1;                                     // R13
          st_nxt     = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    // completion wins over a transmit seen in the same cycle
    dv_n_nxt    = done ? 1'b0 : (tx_start ? 1'b1 : dv_n_r);    // R14 R15 R25
    ovf_clr_nxt = tx_start & ~dv_n_r;
    ovfp_nxt    = (ovfp_r & ~ovf_clr_r) | (coll & ovf_pos_in); // R19
    ovfn_nxt    = (ovfn_r & ~ovf_clr_r) | (coll & ovf_neg_in); // R19
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r       <= ST_IDLE;
      cnt_r      <= '0;
      cont_r     <= 1'b0;
      istart_r   <= 1'b0;
      dv_n_r     <= 1'b1;
      ovf_clr_r  <= 1'b0;
      ovfp_r     <= 1'b0;
      ovfn_r     <= 1'b0;
      res_hold_r <= '0;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      cont_r     <= cont_nxt;
      istart_r   <= istart_nxt;
      dv_n_r     <= dv_n_nxt;
      ovf_clr_r  <= ovf_clr_nxt;
      ovfp_r     <= ovfp_nxt;
      ovfn_r     <= ovfn_nxt;
      res_hold_r <= res_hold_nxt;
    end
  end

  // ----------------------------------------
  // serial result and setup readback path
  // ----------------------------------------
  logic [`ADCS_RES_W-1:0] res_q;
  logic [`ADCS_CFG_W-1:0] rb_q;
  logic                   res_shift;
  logic                   rb_load;
  logic                   rb_shift;
  logic                   rb_loaded_r;
  logic                   rb_loaded_nxt;
  logic                   dout_r;
  logic                   dout_nxt;
  logic                   dout_oe_r;
  logic                   dout_oe_nxt;
  logic                   test_r;
  logic                   test_nxt;

  assign res_shift = dclk_fall & tx_on & pins_s.rdsel & ~done;   // R21 R24
  assign rb_load   = dclk_rise & ~pins_s.rdsel & ~rb_loaded_r;   // R4
  assign rb_shift  = dclk_fall & tx_on & ~pins_s.rdsel;          // R5 R21

  adcs_shift #(.W(`ADCS_RES_W)) u_res_sr (
    .clk      (mclk),
    .rst_n    (resetn),
    .load     (done),
    .load_val (conv_result),
    .shift    (res_shift),
    .sin      (pins_s.din),
    .q        (res_q)
  );

  // readback copy is separate, so the result register is never disturbed
  adcs_shift #(.W(`ADCS_CFG_W)) u_rb_sr (
    .clk      (mclk),
    .rst_n    (resetn),
    .load     (rb_load),
    .load_val (cfg_r),
    .shift    (rb_shift),
    .sin      (pins_s.din),
    .q        (rb_q)
  );

  always_comb begin
    rb_loaded_nxt = pins_s.rdsel ? 1'b0 : (rb_loaded_r | dclk_rise);
    if (pins_s.rdsel) begin
      // straight binary taps one bit lower, so chain bits follow after 20
      dout_nxt = cfg_r.fmt_twos ? res_q[`ADCS_MSB_TC] : res_q[`ADCS_MSB_SB]; // R3 R23
    end else begin
      dout_nxt = rb_q[`ADCS_CFG_W-1];                            // R5
    end
    dout_oe_nxt = tx_on;                                         // R15 R16
    test_nxt    = pins_s.test | ctrl_r[`ADCS_CTRL_TEST];         // R10
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rb_loaded_r <= 1'b0;
      dout_r      <= 1'b0;
      dout_oe_r   <= 1'b0;
      test_r      <= 1'b0;
    end else begin
      rb_loaded_r <= rb_loaded_nxt;
      dout_r      <= dout_nxt;
      dout_oe_r   <= dout_oe_nxt;
      test_r      <= test_nxt;
    end
  end

  // ----------------------------------------
  // register slave
  // ----------------------------------------
  logic                   aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [`ADCS_AW-1:0]    aw_addr_r, aw_addr_nxt;
  logic [31:0]            w_data_r, w_data_nxt;
  logic                   w_strb0_r, w_strb0_nxt;
  logic                   awready_r, awready_nxt, wready_r, wready_nxt;
  logic                   bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic                   rvalid_r, rvalid_nxt;
  logic [1:0]             bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]            rdata_r, rdata_nxt;
  logic [1:0]             ctrl_nxt;

  function automatic logic is_mapped(input logic [31:0] a);
    is_mapped = (a[31:`ADCS_AW] == '0) &&
                (a[`ADCS_AW-1:0] == `ADCS_OFS_CTRL || a[`ADCS_AW-1:0] == `ADCS_OFS_STAT ||
                 a[`ADCS_AW-1:0] == `ADCS_OFS_RES || a[`ADCS_AW-1:0] == `ADCS_OFS_CFG);
  endfunction

  always_comb begin
    aw_have_nxt = aw_have_r | (awvalid & awready_r);
    aw_addr_nxt = (awvalid & awready_r) ? awaddr[`ADCS_AW-1:0] : aw_addr_r;
    w_have_nxt  = w_have_r | (wvalid & wready_r);
    w_data_nxt  = (wvalid & wready_r) ? wdata : w_data_r;
    w_strb0_nxt = (wvalid & wready_r) ? wstrb[0] : w_strb0_r;
    bvalid_nxt  = bvalid_r & ~bready;
    bresp_nxt   = bresp_r;
    ctrl_nxt    = ctrl_r;
    if (aw_have_r && w_have_r && !bvalid_r) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = is_mapped({20'h00000, aw_addr_r}) ? `ADCS_RESP_OK : `ADCS_RESP_ERR;
      if (aw_addr_r == `ADCS_OFS_CTRL && w_strb0_r) begin
        ctrl_nxt = w_data_r[1:0];
      end
    end
    awready_nxt = ~aw_have_nxt & ~bvalid_nxt;
    wready_nxt  = ~w_have_nxt & ~bvalid_nxt;
    rvalid_nxt  = rvalid_r & ~rready;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = is_mapped(araddr) ? `ADCS_RESP_OK : `ADCS_RESP_ERR;
      unique case (araddr[`ADCS_AW-1:0])
        `ADCS_OFS_CTRL: rdata_nxt = {30'h0000000, ctrl_r};
        `ADCS_OFS_STAT: rdata_nxt = {24'h000000, 1'b0, st_r, ovfn_r, ovfp_r, ~dv_n_r,
                                     cap_cnt_r == 4'h0};
        `ADCS_OFS_RES:  rdata_nxt = {11'h00, res_hold_r};
        `ADCS_OFS_CFG:  rdata_nxt = {20'h00000, cfg_r};
        default:        rdata_nxt = 32'h00000000;
      endcase
      if (!is_mapped(araddr)) begin
        rdata_nxt = 32'h00000000;
      end
    end
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {aw_have_r, w_have_r, w_strb0_r, bvalid_r, rvalid_r} <= 5'h00;
      {awready_r, wready_r, arready_r} <= 3'h0;
      aw_addr_r <= '0;
      w_data_r  <= 32'h00000000;
      bresp_r   <= `ADCS_RESP_OK;
      rresp_r   <= `ADCS_RESP_OK;
      rdata_r   <= 32'h00000000;
      ctrl_r    <= `ADCS_CTRL_RST;
    end else begin
      {aw_have_r, w_have_r, w_strb0_r} <= {aw_have_nxt, w_have_nxt, w_strb0_nxt};
      {bvalid_r, rvalid_r} <= {bvalid_nxt, rvalid_nxt};
      {awready_r, wready_r, arready_r} <= {awready_nxt, wready_nxt, arready_nxt};
      aw_addr_r <= aw_addr_nxt;
      w_data_r  <= w_data_nxt;
      bresp_r   <= bresp_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  assign {awready, wready, arready} = {awready_r, wready_r, arready_r};
  assign {bvalid, bresp, rvalid, rresp, rdata} = {bvalid_r, bresp_r, rvalid_r, rresp_r, rdata_r};
  assign {dout, dout_oe, data_valid_n} = {dout_r, dout_oe_r, dv_n_r};
  assign {ovf_pos_pull, ovf_neg_pull} = {ovfp_r, ovfn_r};
  assign {test_src_en, integ_start} = {test_r, istart_r};

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_dv_on_done: assert property (done |=> !data_valid_n) // R14
    else $error("data valid did not fall after completion");
  a_dv_on_tx: assert property (tx_start && !done |=> data_valid_n) // R15
    else $error("data valid not released on transmit");
  a_dv_held: assert property (!data_valid_n && !tx_start ##1 !done |-> !data_valid_n) // R25
    else $error("data valid dropped without transmit");
  a_out_float: assert property (pins_s.xmit_n |=> !dout_oe) // R16
    else $error("serial output driven while transmit high");
  a_cfg_reset: assert property (!pins_s.setup_rst_n |=> cfg_r == '0 && cap_cnt_r == 4'(`ADCS_CFG_W)) // R9
    else $error("setup reset did not rearm capture");
  a_cont_restart: assert property (integ_start && cont_r |-> $past(cnt_r) == $past(m_cnt)) // R22
    else $error("continuous restart not at oversampling count");
  a_async_restart: assert property (st_r == ST_HOLD && pins_s.trig_n |=> integ_start) // R13
    else $error("async integration did not restart");
  a_ovf_clear: assert property (ovf_clr_r && !coll |=> !ovf_pos_pull && !ovf_neg_pull) // R19
    else $error("overflow flags not cleared");
  a_rb_keeps: assert property (!pins_s.rdsel && !done |=> $stable(res_q)) // R6
    else $error("readback disturbed result register");
  a_shift_fall: assert property ($changed(res_q) && !$past(done) |-> $past(dclk_fall)) // R21
    else $error("result advanced without falling data clock");

  c_conversion: cover property (done ##[1:50] tx_start);
  c_cont_mode: cover property (integ_start && cont_r);
  c_readback: cover property (rb_load ##[1:40] rb_shift);
  c_cfg_full: cover property ($fell(cap_cnt_r != 4'h0));
endmodule

// ### adcs_defines.svh
// constants for the converter setup and serial port block
// assumes inclusion by bare name from each file that uses its macros
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

`define ADCS_CFG_W      12
`define ADCS_RES_W      21
`define ADCS_OSR_W      6
`define ADCS_CNT_W      7
`define ADCS_MSB_SB     19
`define ADCS_MSB_TC     20
`define ADCS_AW         12
`define ADCS_OFS_CTRL   12'h000
`define ADCS_OFS_STAT   12'h004
`define ADCS_OFS_RES    12'h008
`define ADCS_OFS_CFG    12'h00C
`define ADCS_CTRL_CONT  0
`define ADCS_CTRL_TEST  1
`define ADCS_CTRL_RST   2'h0
`define ADCS_RESP_OK    2'h0
`define ADCS_RESP_ERR   2'h2

`endif

// ### adcs_pkg.sv
// types shared by the converter setup and serial port block
// assumes adcs_defines.svh is on the include path
`include "adcs_defines.svh"
package adcs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_COLLECT = 3'b010,
    ST_HOLD    = 3'b100
  } adcs_state_t;

  // 12-bit setup word, first bit shifted in ends at fmt_twos
  typedef struct packed {
    logic                   fmt_twos;
    logic [4:0]             spare;
    logic [`ADCS_OSR_W-1:0] osr;
  } adcs_cfg_t;

  // pins from outside the mclk domain, synchronised as one group
  typedef struct packed {
    logic dclk;
    logic din;
    logic xmit_n;
    logic rdsel;
    logic setup_din;
    logic setup_rst_n;
    logic trig_n;
    logic test;
  } adcs_pins_t;

endpackage

// ### adcs_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes inputs may change at any time relative to clk
`timescale 1ns/1ps
module adcs_sync #(
  parameter int          W   = 8,
  parameter logic [W-1:0] INI = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= INI;
      q_r    <= INI;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end
  assign q = q_r;
endmodule

// ### adcs_shift.sv
// loadable shift register, serial in at bit 0, msb first out
// assumes load and shift are single mclk enables
`timescale 1ns/1ps
module adcs_shift #(
  parameter int W = 21
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         shift,
  input  wire logic         sin,
  output logic      [W-1:0] q
);
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (load) begin
      q_nxt = load_val;
    end else if (shift) begin
      q_nxt = {q_r[W-2:0], sin};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
  assign q = q_r;
endmodule

// ### adcs_host.sv
// host-side model of the serial pins: setup load and result/readback shifting
// assumes mclk-domain sampling in the block; dclk runs 160 ns, phase set by delays
`timescale 1ns/1ps
module adcs_host (
  output logic dclk,
  output logic din,
  output logic xmit_n,
  output logic rdsel,
  output logic setup_din,
  output logic setup_rst_n,
  input  wire logic dout,
  input  wire logic dout_oe
);
  logic dout_line;

  // no pull on the line: a released output shows the inverse of its last bit
  assign dout_line = dout_oe ? dout : ~dout;

  // chain input stands at 1 so chained bits differ from a result ending in 0
  initial begin
    dclk        = 1'b0;
    din         = 1'b1;
    xmit_n      = 1'b1;
    rdsel       = 1'b1;
    setup_din   = 1'b0;
    setup_rst_n = 1'b1;
  end

  // ----------------------------------------
  // setup word load, msb first
  // ----------------------------------------
  task automatic load_setup(input logic [11:0] w);
    #7;
    setup_rst_n = 1'b0;
    #200;
    setup_rst_n = 1'b1;
    #200;
    for (int i = 11; i >= 0; i--) begin
      setup_din = w[i];
      #80 dclk = 1'b1;
      #80 dclk = 1'b0;
    end
    // bit hold over: show the inverse rather than a stale value
    setup_din = ~w[0];
  endtask

  // ----------------------------------------
  // shift n bits, sampled just before each falling dclk
  // ----------------------------------------
  task automatic shift(input int n, input logic rb, output logic [31:0] got);
    got = '0;
    #7;
    rdsel = rb;
    dclk  = 1'b0;
    #100 xmit_n = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      #80 dclk = 1'b1;
      #80 got = {got[30:0], dout_line};
      dclk = 1'b0;
    end
    #100 xmit_n = 1'b1;
    rdsel = 1'b1;
  endtask
endmodule

// ### adc_serial_setup_port_tb.sv
// self-checking bench: register bus tasks plus pin-level conversion and shifting
// assumes adcs_top and adcs_host; all pins async to mclk
`timescale 1ns/1ps
`include "adcs_defines.svh"
module adc_serial_setup_port_tb;
  logic        mclk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, dout, dout_oe, data_valid_n;
  logic        ovf_pos_pull, ovf_neg_pull, test_src_en, integ_start;
  logic        final_point_trigger_n, test_in, ovf_pos_in, ovf_neg_in;
  logic        dclk, din, xmit_n, rdsel, setup_din, setup_rst_n;
  logic [31:0] awaddr, wdata, araddr, rdata, got;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [20:0] conv_result;
  int          err_total, n_tests;

  adcs_top dut (.mclk, .resetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .dclk, .din, .xmit_n, .rdsel, .setup_din, .setup_rst_n, .final_point_trigger_n, .test_in,
    .conv_result, .ovf_pos_in, .ovf_neg_in, .dout, .dout_oe, .data_valid_n, .ovf_pos_pull,
    .ovf_neg_pull, .test_src_en, .integ_start);
  adcs_host host (.dclk, .din, .xmit_n, .rdsel, .setup_din, .setup_rst_n, .dout, .dout_oe);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic axr(input logic [31:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // trigger pulse of pw cycles, then wait for completion
  task automatic convert(input logic [20:0] r, input int pw, input logic cont);
    int   k;
    logic seen;
    @(posedge mclk);
    conv_result           <= r;
    ovf_pos_in            <= ~cont;
    ovf_neg_in            <= cont;
    final_point_trigger_n <= 1'b0;
    repeat (pw) @(posedge mclk);
    final_point_trigger_n <= 1'b1;
    k = 0;
    while (data_valid_n !== 1'b0 && k < 200) begin
      @(posedge mclk);
      k++;
    end
    chk({31'h0, data_valid_n}, 32'h0);
    if (cont) chk({31'h0, integ_start}, 32'h1);
    {ovf_pos_in, ovf_neg_in} <= 2'b00;
    seen = 1'b0;
    repeat (10) begin
      @(posedge mclk);
      seen = seen | integ_start;
    end
    if (!cont) chk({31'h0, seen}, 32'h1);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    summarize();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    err_total = 0;
    n_tests = 0;
    {resetn, awvalid, wvalid, bready, arvalid, rready, test_in, ovf_pos_in, ovf_neg_in} = '0;
    final_point_trigger_n = 1'b1;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hF;
    conv_result = '0;
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({28'h0, data_valid_n, dout_oe, test_src_en, integ_start}, 32'h8);
    axr(32'h10, `ADCS_RESP_ERR, got);
    chk(got, 32'h0);
    axw(32'h10, 32'h1, `ADCS_RESP_ERR);
    axw(`ADCS_OFS_CTRL, 32'h0, `ADCS_RESP_OK);
    wstrb <= 4'hE;
    axw(`ADCS_OFS_CTRL, 32'h3, `ADCS_RESP_OK);
    wstrb <= 4'hF;
    axr(`ADCS_OFS_CTRL, `ADCS_RESP_OK, got);
    chk(got & 32'h3, 32'h0);
    $display("bus test done");

    host.load_setup(12'h805);
    repeat (10) @(posedge mclk);
    axr(`ADCS_OFS_CFG, `ADCS_RESP_OK, got);
    chk(got, 32'h805);
    axr(`ADCS_OFS_STAT, `ADCS_RESP_OK, got);
    chk(got & 32'h1, 32'h1);
    test_in <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({31'h0, test_src_en}, 32'h1);
    test_in <= 1'b0;
    repeat (6) @(posedge mclk);
    chk({31'h0, test_src_en}, 32'h0);
    axw(`ADCS_OFS_CTRL, 32'h2, `ADCS_RESP_OK);
    repeat (2) @(posedge mclk);
    chk({31'h0, test_src_en}, 32'h1);
    $display("setup test done");

    convert(21'h1A5A5A, 8, 1'b0);
    repeat (20) @(posedge mclk);
    chk({30'h0, data_valid_n, ovf_pos_pull}, 32'h1);
    axr(`ADCS_OFS_RES, `ADCS_RESP_OK, got);
    chk(got, 32'h1A5A5A);
    host.shift(12, 1'b0, got);
    chk(got & 32'hFFF, 32'h805);
    chk({30'h0, data_valid_n, ovf_pos_pull}, 32'h2);
    host.shift(23, 1'b1, got);
    chk(got & 32'h7FFFFF, {9'h0, 21'h1A5A5A, 2'b11});
    repeat (6) @(posedge mclk);
    chk({31'h0, dout_oe}, 32'h0);
    $display("async conversion test done");

    host.load_setup(12'h003);
    repeat (10) @(posedge mclk);
    axr(`ADCS_OFS_RES, `ADCS_RESP_OK, got);
    chk(got, 32'h1A5A5A);
    axr(`ADCS_OFS_CFG, `ADCS_RESP_OK, got);
    chk(got, 32'h003);
    axw(`ADCS_OFS_CTRL, 32'h1, `ADCS_RESP_OK);
    convert(21'h0F0F0E, 2, 1'b1);
    chk({30'h0, data_valid_n, ovf_neg_pull}, 32'h1);
    host.shift(22, 1'b1, got);
    chk(got & 32'h3FFFFF, {10'h0, 20'hF0F0E, 2'b11});
    chk({30'h0, data_valid_n, ovf_neg_pull}, 32'h2);
    $display("continuous conversion test done");
    summarize();
  end
endmodule
